/* File: pkg/rtcar_map.svh */
`ifndef RTCAR_MAP_SVH
`define RTCAR_MAP_SVH
// Register offsets
`define RTCAR_ADDR_SECONDS     5'h00
`define RTCAR_ADDR_MINUTES     5'h01
`define RTCAR_ADDR_HOURS       5'h02
`define RTCAR_ADDR_WEEKDAY     5'h03
`define RTCAR_ADDR_MONTH_DAY   5'h04
`define RTCAR_ADDR_MONTH       5'h05
`define RTCAR_ADDR_YEAR        5'h06
`define RTCAR_ADDR_A1_SECONDS  5'h07
`define RTCAR_ADDR_A1_MINUTES  5'h08
`define RTCAR_ADDR_A1_HOURS    5'h09
`define RTCAR_ADDR_A1_DAY_DATE 5'h0A
`define RTCAR_ADDR_A2_MINUTES  5'h0B
`define RTCAR_ADDR_A2_HOURS    5'h0C
`define RTCAR_ADDR_A2_DAY_DATE 5'h0D
`define RTCAR_ADDR_CONTROL     5'h0E
`define RTCAR_ADDR_STATUS      5'h0F
`define RTCAR_ADDR_TRIM        5'h10
`define RTCAR_ADDR_TEMP_HIGH   5'h11
`define RTCAR_ADDR_TEMP_LOW    5'h12
`define RTCAR_ADDR_LAST        5'h12
// Field positions
`define RTCAR_HOURS_FORMAT_BIT 6
`define RTCAR_MERIDIEM_BIT     5
`define RTCAR_CENTURY_BIT      7
`define RTCAR_ALARM_MASK_BIT   7
`define RTCAR_DAY_SELECT_BIT   6
`define RTCAR_CTRL_OSC_STOP    7
`define RTCAR_CTRL_BAT_SQW     6
`define RTCAR_CTRL_CONVERT     5
`define RTCAR_CTRL_OUT_SELECT  2
`define RTCAR_CTRL_A2_ENABLE   1
`define RTCAR_CTRL_A1_ENABLE   0
`define RTCAR_STAT_OSC_FLAG    7
`define RTCAR_STAT_KHZ_ENABLE  3
`define RTCAR_STAT_A2_FLAG     1
`define RTCAR_STAT_A1_FLAG     0
// Reset values
`define RTCAR_RESET_WEEKDAY    8'h01
`define RTCAR_RESET_MONTH_DAY  8'h01
`define RTCAR_RESET_MONTH      8'h01
`define RTCAR_RESET_CONTROL    8'h1C
`define RTCAR_RESET_STATUS     8'h88
// Timing
`define RTCAR_SECOND_MS        1000
`define RTCAR_CLK_PERIOD_NS    10
`endif

/* File: pkg/rtcar_pkg.sv */
package rtcar_pkg;
   // Request kinds passed from the link side
   typedef enum logic [1:0] {
      RTCAR_REQ_START   = 2'b00,
      RTCAR_REQ_POINTER = 2'b01,
      RTCAR_REQ_WRITE   = 2'b10,
      RTCAR_REQ_READ    = 2'b11
   } rtcar_req_type;

   // Core (clk) domain state
   typedef struct packed {
      logic [18:0][7:0] regs;      // Live register file
      logic [6:0][7:0]  shadow;    // Time snapshot for reads
      logic [4:0]       ptr;       // Register pointer
      logic [31:0]      count;     // Sub-second up-counting chain
      logic [2:0]       reqSync;   // Request toggle synchroniser
      logic             reqSeen;   // Last request toggle handled
      logic             ackToggle; // Answer toggle to link side
      logic [7:0]       readData;  // Byte answered to a read
      logic             irqN;      // Pin pull-down control
   } rtcar_core_state_type;

   // Link (linkClk) domain state
   typedef struct packed {
      logic          reqToggle; // Request toggle to core
      rtcar_req_type kind;      // Held request kind
      logic [7:0]    data;      // Held request byte
      logic          busy;      // Request outstanding
      logic [2:0]    ackSync;   // Answer toggle synchroniser
      logic          ackSeen;   // Last answer toggle handled
      logic [7:0]    readData;  // Byte returned to the engine
      logic          readValid; // One-cycle read answer strobe
   } rtcar_link_state_type;
endpackage

/* File: core/rtcar_calendar_alarm_regs.sv */
// Overview of operation
// R1: Pointer wraps from last register to zero
// R2: START or wrap to zero snapshots time
// R3: Time registers hold packed BCD digits
// R4: Hours bit 6 selects twelve-hour mode
// R5: Bit 5 is PM flag or twenties
// R6: Century flag toggles on year 99 to 00
// R7: Weekday advances at midnight, cycles 1..7
// R8: Seconds write restarts the sub-second chain
// R9: Written byte commits at its acknowledge
// R10: Host finishes time writes within one second
// R11: Alarm one at 07-0A, two at 0B-0D
// R12: All masks clear needs every field match
// R13: Day/date select bit picks weekday or date
// R14: Matching alarm sets its flag
// R15: Alarm drives pin if flag, enable, select
// R16: Alarms checked only on once-per-second update
// R17: First alarm mask patterns choose match fields
// R18: Second alarm mask patterns, minute at zero
// R19: Power-up register contents need not be defined
// R20: Select zero gives 1 Hz square wave
// R21: Pointer increments after each transferred byte
`timescale 1ns/1ps
`include "rtcar_map.svh"

module rtcar_calendar_alarm_regs
   import rtcar_pkg::*;
#(
   parameter int SECOND_CYCLES = `RTCAR_SECOND_MS * 1000000 / `RTCAR_CLK_PERIOD_NS
)
(
   // Core clock and reset
   input  wire logic       clk,
   input  wire logic       rst,
   // Link clock and reset (byte engine side)
   input  wire logic       linkClk,
   input  wire logic       linkRst,
   // Byte engine requests, one-cycle pulses on linkClk
   input  wire logic       linkStart,
   input  wire logic       linkPointerLoad,
   input  wire logic       linkWriteByte,
   input  wire logic       linkReadByte,
   input  wire logic [7:0] linkData,
   // Byte engine answers on linkClk
   output logic            linkBusy,
   output logic [7:0]      linkReadData,
   output logic            linkReadValid,
   // Same-domain status inputs
   input  wire logic       oscillatorStopped,
   input  wire logic [7:0] temperatureHigh,
   input  wire logic [7:0] temperatureLow,
   // Control outputs
   output logic            oscillatorStopOnBattery,
   output logic            batterySquareWaveEnable,
   output logic            forceTempConversion,
   output logic            khzOutputEnable,
   // Open-drain interrupt/square-wave pin, enable low pulls low
   output logic            irqOrSquareWaveOeN
);

   localparam logic [31:0] LAST_COUNT = 32'(SECOND_CYCLES - 1); // Chain terminal value
   localparam logic [31:0] HALF_COUNT = 32'(SECOND_CYCLES / 2); // Square wave half period

   // Reject periods the chain cannot count
   if (SECOND_CYCLES < 4)
   begin : g_check
      $error("SECOND_CYCLES must be at least 4");
   end

   rtcar_core_state_type s, next_s;         // Core state
   rtcar_link_state_type ls, next_ls;       // Link state
   logic                 tick;              // Once-per-second update
   logic                 evt;               // Request arrived from link
   logic                 midnight;          // Day boundary on this tick
   logic                 yearWrap;          // Year rolls 99 to 00
   logic                 a1Match, a2Match;  // Alarm comparisons
   logic                 sqw;               // 1 Hz square wave level
   logic [6:0][7:0]      nextTime;          // Time after the tick

   // Packed BCD step: {wrap, next}, returns first past lim
   function automatic logic [8:0] bcd_step(input logic [7:0] v, input logic [7:0] lim,
                                           input logic [7:0] first);
      if (v >= lim)
      begin
         return {1'b1, first};
      end
      else if (v[3:0] >= 4'h9)
      begin
         return {1'b0, 4'(v[7:4] + 4'h1), 4'h0};
      end
      return {1'b0, v[7:4], 4'(v[3:0] + 4'h1)};
   endfunction

   // Days in a month with leap years
   function automatic logic [7:0] month_len(input logic [7:0] mon, input logic [7:0] yr);
      logic leap;
      leap = yr[4] ? (yr[3:0] == 4'h2 || yr[3:0] == 4'h6)
                   : (yr[3:0] == 4'h0 || yr[3:0] == 4'h4 || yr[3:0] == 4'h8);
      if (mon == 8'h02)
      begin
         return leap ? 8'h29 : 8'h28;
      end
      else if (mon == 8'h04 || mon == 8'h06 || mon == 8'h09 || mon == 8'h11)
      begin
         return 8'h30;
      end
      return 8'h31;
   endfunction

   // Core next-state logic
   always_comb
   begin
      logic [8:0] r;
      logic [7:0] h, hr, rd;
      logic       dayWrap, monWrap;
      r = '0;
      h = '0;
      hr = '0;
      rd = '0;
      dayWrap = 1'b0;
      monWrap = 1'b0;
      next_s = s;
      midnight = 1'b0;
      yearWrap = 1'b0;
      nextTime = s.regs[6:0];
      // Sub-second chain
      tick = (s.count >= LAST_COUNT);
      next_s.count = tick ? 32'h0 : 32'(s.count + 32'h1);
      // Calendar advance, all fields BCD [R3]
      r = bcd_step({1'b0, s.regs[0][6:0]}, 8'h59, 8'h00);
      nextTime[0] = r[7:0];
      if (r[8])
      begin
         r = bcd_step({1'b0, s.regs[1][6:0]}, 8'h59, 8'h00);
         nextTime[1] = r[7:0];
         if (r[8])
         begin
            h = s.regs[2];
            if (h[`RTCAR_HOURS_FORMAT_BIT]) // Twelve-hour counting [R4]
            begin
               hr = {3'h0, h[4:0]};
               if (hr == 8'h11) // Meridiem flips, PM to AM is midnight [R5]
               begin
                  nextTime[2] = {h[7:6], ~h[`RTCAR_MERIDIEM_BIT], 5'h12};
                  midnight = h[`RTCAR_MERIDIEM_BIT];
               end
               else if (hr >= 8'h12)
               begin
                  nextTime[2] = {h[7:5], 5'h01};
               end
               else
               begin
                  r = bcd_step(hr, 8'h12, 8'h01);
                  nextTime[2] = {h[7:5], r[4:0]};
               end
            end
            else // Twenty-four hour, bit 5 is the twenties digit [R5]
            begin
               r = bcd_step({2'h0, h[5:0]}, 8'h23, 8'h00);
               nextTime[2] = {h[7:6], r[5:0]};
               midnight = r[8];
            end
         end
      end
      // Day boundary: weekday, date, month, year
      if (midnight)
      begin
         r = bcd_step({5'h0, s.regs[3][2:0]}, 8'h07, 8'h01); // [R7]
         nextTime[3] = r[7:0];
         r = bcd_step({2'h0, s.regs[4][5:0]}, month_len({3'h0, s.regs[5][4:0]}, s.regs[6]), 8'h01);
         nextTime[4] = r[7:0];
         dayWrap = r[8];
      end
      if (dayWrap)
      begin
         r = bcd_step({3'h0, s.regs[5][4:0]}, 8'h12, 8'h01);
         nextTime[5] = {s.regs[5][7], 2'h0, r[4:0]};
         monWrap = r[8];
      end
      if (monWrap)
      begin
         r = bcd_step(s.regs[6], 8'h99, 8'h00);
         nextTime[6] = r[7:0];
         yearWrap = r[8];
         nextTime[5][`RTCAR_CENTURY_BIT] = s.regs[5][`RTCAR_CENTURY_BIT] ^ r[8]; // [R6]
      end
      // First alarm: mask bit 7 per field, day/date select [R11] [R12] [R13] [R17]
      a1Match = (s.regs[7][7] || s.regs[7][6:0] == nextTime[0][6:0])
             && (s.regs[8][7] || s.regs[8][6:0] == nextTime[1][6:0])
             && (s.regs[9][7] || s.regs[9][6:0] == nextTime[2][6:0])
             && (s.regs[10][7] || s.regs[10][5:0] ==
                 (s.regs[10][`RTCAR_DAY_SELECT_BIT] ? nextTime[3][5:0] : nextTime[4][5:0]));
      // Second alarm: always at zero seconds [R11] [R12] [R13] [R18]
      a2Match = (nextTime[0][6:0] == 7'h00)
             && (s.regs[11][7] || s.regs[11][6:0] == nextTime[1][6:0])
             && (s.regs[12][7] || s.regs[12][6:0] == nextTime[2][6:0])
             && (s.regs[13][7] || s.regs[13][5:0] ==
                 (s.regs[13][`RTCAR_DAY_SELECT_BIT] ? nextTime[3][5:0] : nextTime[4][5:0]));
      if (tick)
      begin
         next_s.regs[6:0] = nextTime;
      end
      // Link request synchroniser, second and third stages agree
      next_s.reqSync = {s.reqSync[1:0], ls.reqToggle};
      evt = (s.reqSync[1] == s.reqSync[2]) && (s.reqSync[2] != s.reqSeen);
      if (evt)
      begin
         next_s.reqSeen = s.reqSync[2];
         next_s.ackToggle = ~s.ackToggle;
         case (ls.kind)
            RTCAR_REQ_START: // Snapshot live time [R2]
            begin
               next_s.shadow = s.regs[6:0];
            end
            RTCAR_REQ_POINTER: // Load pointer
            begin
               next_s.ptr = ls.data[4:0];
            end
            RTCAR_REQ_WRITE: // Commit at acknowledge [R9]
            begin
               if (s.ptr == `RTCAR_ADDR_STATUS)
               begin
                  // Flags clear on zero, ignore ones
                  next_s.regs[15] = {s.regs[15][7] & ls.data[7], 3'h0, ls.data[3], 1'b0,
                                     s.regs[15][1:0] & ls.data[1:0]};
               end
               else if (s.ptr == `RTCAR_ADDR_SECONDS)
               begin
                  next_s.regs[0] = ls.data;
                  next_s.count = 32'h0; // Restart sub-second chain [R8]
               end
               else if (s.ptr < `RTCAR_ADDR_TEMP_HIGH)
               begin
                  next_s.regs[s.ptr] = ls.data;
               end
            end
            default: // Read, time from snapshot
            begin
               if (s.ptr <= `RTCAR_ADDR_YEAR)
               begin
                  rd = s.shadow[s.ptr];
               end
               else if (s.ptr == `RTCAR_ADDR_TEMP_HIGH)
               begin
                  rd = temperatureHigh;
               end
               else if (s.ptr == `RTCAR_ADDR_TEMP_LOW)
               begin
                  rd = temperatureLow;
               end
               else if (s.ptr < `RTCAR_ADDR_TEMP_HIGH)
               begin
                  rd = s.regs[s.ptr];
               end
               next_s.readData = rd;
            end
         endcase
         // Ascending pointer, wrap to zero snapshots [R21] [R1] [R2]
         if (ls.kind == RTCAR_REQ_WRITE || ls.kind == RTCAR_REQ_READ)
         begin
            if (s.ptr >= `RTCAR_ADDR_LAST)
            begin
               next_s.ptr = 5'h00;
               next_s.shadow = s.regs[6:0];
            end
            else
            begin
               next_s.ptr = 5'(s.ptr + 5'h1);
            end
         end
      end
      // Hardware sets win over software clears [R14] [R16]
      next_s.regs[15][`RTCAR_STAT_A1_FLAG] = next_s.regs[15][`RTCAR_STAT_A1_FLAG] | (tick & a1Match);
      next_s.regs[15][`RTCAR_STAT_A2_FLAG] = next_s.regs[15][`RTCAR_STAT_A2_FLAG] | (tick & a2Match);
      next_s.regs[15][`RTCAR_STAT_OSC_FLAG] = next_s.regs[15][`RTCAR_STAT_OSC_FLAG] | oscillatorStopped;
      // Pin: alarm interrupt or square wave [R15] [R20]
      sqw = (next_s.count < HALF_COUNT);
      if (next_s.regs[14][`RTCAR_CTRL_OUT_SELECT])
      begin
         next_s.irqN = ~((next_s.regs[15][0] & next_s.regs[14][0]) | (next_s.regs[15][1] & next_s.regs[14][1]));
      end
      else
      begin
         next_s.irqN = sqw;
      end
   end

   // Core registers
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         s <= '0; // Defined start values, allowed where power-up is undefined [R19]
         s.regs[3] <= `RTCAR_RESET_WEEKDAY;
         s.regs[4] <= `RTCAR_RESET_MONTH_DAY;
         s.regs[5] <= `RTCAR_RESET_MONTH;
         s.regs[14] <= `RTCAR_RESET_CONTROL;
         s.regs[15] <= `RTCAR_RESET_STATUS;
         s.irqN <= 1'b1;
      end
      else
      begin
         s <= next_s;
      end
   end

   // Link next-state: request handshake and answer capture
   always_comb
   begin
      next_ls = ls;
      next_ls.readValid = 1'b0;
      next_ls.ackSync = {ls.ackSync[1:0], s.ackToggle};
      // Answer seen once second and third stages agree
      if (ls.ackSync[1] == ls.ackSync[2] && ls.ackSync[2] != ls.ackSeen)
      begin
         next_ls.ackSeen = ls.ackSync[2];
         next_ls.busy = 1'b0;
         if (ls.kind == RTCAR_REQ_READ)
         begin
            next_ls.readData = s.readData;
            next_ls.readValid = 1'b1;
         end
      end
      // New request only while idle
      if (!ls.busy)
      begin
         if (linkStart)
         begin
            next_ls.kind = RTCAR_REQ_START;
         end
         else if (linkPointerLoad)
         begin
            next_ls.kind = RTCAR_REQ_POINTER;
         end
         else if (linkWriteByte)
         begin
            next_ls.kind = RTCAR_REQ_WRITE;
         end
         else if (linkReadByte)
         begin
            next_ls.kind = RTCAR_REQ_READ;
         end
         if (linkStart || linkPointerLoad || linkWriteByte || linkReadByte)
         begin
            next_ls.data = linkData;
            next_ls.reqToggle = ~ls.reqToggle;
            next_ls.busy = 1'b1;
         end
      end
   end

   // Link registers
   always_ff @(posedge linkClk)
   begin
      if (linkRst)
      begin
         ls <= '0;
      end
      else
      begin
         ls <= next_ls;
      end
   end

   // Outputs from flops
   assign linkBusy                = ls.busy;
   assign linkReadData            = ls.readData;
   assign linkReadValid           = ls.readValid;
   assign oscillatorStopOnBattery = s.regs[14][`RTCAR_CTRL_OSC_STOP];
   assign batterySquareWaveEnable = s.regs[14][`RTCAR_CTRL_BAT_SQW];
   assign forceTempConversion     = s.regs[14][`RTCAR_CTRL_CONVERT];
   assign khzOutputEnable         = s.regs[15][`RTCAR_STAT_KHZ_ENABLE];
   assign irqOrSquareWaveOeN      = s.irqN;

   // Assertion helpers
   logic [6:0][7:0] liveTime;
   logic            a1Flag, a2Flag, century;
   assign liveTime = s.regs[6:0];
   assign a1Flag   = s.regs[15][`RTCAR_STAT_A1_FLAG];
   assign a2Flag   = s.regs[15][`RTCAR_STAT_A2_FLAG];
   assign century  = s.regs[5][`RTCAR_CENTURY_BIT];

   sequence s_byte_req;
      evt && (ls.kind == RTCAR_REQ_WRITE || ls.kind == RTCAR_REQ_READ);
   endsequence
   sequence s_seconds_write;
      evt && ls.kind == RTCAR_REQ_WRITE && s.ptr == `RTCAR_ADDR_SECONDS;
   endsequence

   property p_ptr_wrap;
      @(posedge clk) disable iff (rst)
      (s_byte_req and s.ptr == `RTCAR_ADDR_LAST) |=> (s.ptr == 5'h00 && s.shadow == $past(liveTime));
   endproperty
   a_ptr_wrap: assert property (p_ptr_wrap) else $error("pointer did not wrap with snapshot"); // [R1]

   property p_snapshot;
      @(posedge clk) disable iff (rst)
      (evt && ls.kind == RTCAR_REQ_START) |=> s.shadow == $past(liveTime);
   endproperty
   a_snapshot: assert property (p_snapshot) else $error("start did not snapshot time"); // [R2]

   property p_twelve_hour;
      @(posedge clk) disable iff (rst)
      (tick && s.regs[1] == 8'h59 && s.regs[0] == 8'h59 && s.regs[2] == 8'h51 && !evt) |=> s.regs[2] == 8'h72;
   endproperty
   a_twelve_hour: assert property (p_twelve_hour) else $error("11 AM did not become 12 PM"); // [R5]

   property p_century;
      @(posedge clk) disable iff (rst)
      (tick && yearWrap && !evt) |=> century != $past(century) && s.regs[6] == 8'h00;
   endproperty
   a_century: assert property (p_century) else $error("century flag did not toggle"); // [R6]

   property p_weekday;
      @(posedge clk) disable iff (rst)
      (tick && midnight && s.regs[3] == 8'h07 && !evt) |=> s.regs[3] == 8'h01;
   endproperty
   a_weekday: assert property (p_weekday) else $error("weekday did not cycle to 1"); // [R7]

   property p_chain_reset;
      @(posedge clk) disable iff (rst)
      s_seconds_write |=> s.count == 32'h0 ##1 s.count == 32'h1;
   endproperty
   a_chain_reset: assert property (p_chain_reset) else $error("seconds write left chain running"); // [R8]

   property p_commit;
      @(posedge clk) disable iff (rst)
      (evt && ls.kind == RTCAR_REQ_WRITE && s.ptr >= `RTCAR_ADDR_A1_SECONDS && s.ptr <= `RTCAR_ADDR_CONTROL)
      |=> s.regs[$past(s.ptr)] == $past(ls.data);
   endproperty
   a_commit: assert property (p_commit) else $error("written byte not committed"); // [R9]

   property p_flag_on_tick;
      @(posedge clk) disable iff (rst)
      $rose(a1Flag) |-> $past(tick);
   endproperty
   a_flag_on_tick: assert property (p_flag_on_tick) else $error("alarm flag set off the tick"); // [R16]

   property p_minute_alarm;
      @(posedge clk) disable iff (rst)
      (tick && s.regs[11][7] && s.regs[12][7] && s.regs[13][7] && nextTime[0] == 8'h00) |=> a2Flag;
   endproperty
   a_minute_alarm: assert property (p_minute_alarm) else $error("minute alarm missed"); // [R18]

   property p_irq;
      @(posedge clk) disable iff (rst)
      (s.regs[14][`RTCAR_CTRL_OUT_SELECT] && a1Flag && s.regs[14][`RTCAR_CTRL_A1_ENABLE] && !evt)
      |=> !irqOrSquareWaveOeN;
   endproperty
   a_irq: assert property (p_irq) else $error("enabled alarm did not pull pin"); // [R15]

   property p_square_wave;
      @(posedge clk) disable iff (rst)
      (!s.regs[14][`RTCAR_CTRL_OUT_SELECT] && s.count == HALF_COUNT && !evt) |=> !irqOrSquareWaveOeN;
   endproperty
   a_square_wave: assert property (p_square_wave) else $error("square wave not low in second half"); // [R20]

endmodule // rtcar_calendar_alarm_regs

/* File: testbench/rtcar_host_model.sv */
`timescale 1ns/1ps
// Host byte engine: one request at a time, pulse held for one link cycle
module rtcar_host_model
   import rtcar_pkg::*;
(
   // Link clock and answers
   input  wire logic       linkClk,
   input  wire logic       linkBusy,
   input  wire logic [7:0] linkReadData,
   input  wire logic       linkReadValid,
   // Requests
   output logic            linkStart,
   output logic            linkPointerLoad,
   output logic            linkWriteByte,
   output logic            linkReadByte,
   output logic [7:0]      linkData
);
   // Idle at time zero
   initial {linkStart, linkPointerLoad, linkWriteByte, linkReadByte, linkData} = 12'h000;

   // Issue one request, then wait a bounded time for its answer
   task automatic send(input rtcar_req_type kind, input logic [7:0] d, output logic [7:0] rd);
      rd = 8'hXX;
      @(posedge linkClk);
      linkStart       <= (kind == RTCAR_REQ_START);
      linkPointerLoad <= (kind == RTCAR_REQ_POINTER);
      linkWriteByte   <= (kind == RTCAR_REQ_WRITE);
      linkReadByte    <= (kind == RTCAR_REQ_READ);
      linkData        <= d;
      @(posedge linkClk);
      {linkStart, linkPointerLoad, linkWriteByte, linkReadByte} <= 4'h0;
      // Released data shows the inverse, never a stale copy
      linkData <= ~d;
      repeat (200)
      begin
         @(posedge linkClk);
         #1;
         if (linkReadValid)
            rd = linkReadData;
         if (!linkBusy)
            break;
      end
      // An answer that never came counts as a mismatch
      if (linkBusy !== 1'b0)
         rtcar_calendar_alarm_regs_tb_top.miscompares++;
   endtask
endmodule // rtcar_host_model

/* File: testbench/rtcar_calendar_alarm_regs_tb_top.sv */
`timescale 1ns/1ps
// Host tasks, rollover table, alarms, pin modes
module rtcar_calendar_alarm_regs_tb_top
   import rtcar_pkg::*;
;
   localparam int SEC = 2000; // Short second in clk cycles
   // Alarm setup 07..0D: 10:00:02 on weekday 5, second alarm every minute
   localparam logic [6:0][7:0] ALARMS = 56'h80_80_80_45_10_00_02;
   // Clocks, resets and pins
   logic       clk = 1'b0;
   logic       linkClk = 1'b0;
   logic       rst = 1'b1;
   logic       linkRst = 1'b1;
   logic       linkStart, linkPointerLoad, linkWriteByte, linkReadByte, linkBusy, linkReadValid;
   logic [7:0] linkData, linkReadData, junk;
   logic       stopOsc, batSqw, convert, khzOn, pinOeN;
   int         miscompares = 0; // Mismatches
   int         checksDone = 0;  // Comparisons
   int         lows;            // Low cycles of the pin
   // Time written, seconds first, and the time one tick later
   logic [6:0][7:0] setT [4] = '{56'h99_12_31_07_23_59_59, 56'h24_06_15_03_71_59_59,
                                 56'h23_02_28_02_51_59_59, 56'h00_01_09_05_09_59_59};
   logic [6:0][7:0] expT [4] = '{56'h00_81_01_01_00_00_00, 56'h24_06_16_04_52_00_00,
                                 56'h23_02_28_02_72_00_00, 56'h00_01_09_05_10_00_00};

   // Core clock
   always #5 clk = ~clk;
   // Link clock, phase offset from the core clock
   initial
   begin
      #7.3;
      forever #15 linkClk = ~linkClk;
   end

   rtcar_calendar_alarm_regs #(.SECOND_CYCLES(SEC)) u_rtcar_calendar_alarm_regs (
      .clk(clk), .rst(rst), .linkClk(linkClk), .linkRst(linkRst), .linkStart(linkStart),
      .linkPointerLoad(linkPointerLoad), .linkWriteByte(linkWriteByte), .linkReadByte(linkReadByte),
      .linkData(linkData), .linkBusy(linkBusy), .linkReadData(linkReadData),
      .linkReadValid(linkReadValid), .oscillatorStopped(1'b0), .temperatureHigh(8'hA5),
      .temperatureLow(8'h40), .oscillatorStopOnBattery(stopOsc), .batterySquareWaveEnable(batSqw),
      .forceTempConversion(convert), .khzOutputEnable(khzOn), .irqOrSquareWaveOeN(pinOeN));

   rtcar_host_model u_rtcar_host_model (
      .linkClk(linkClk), .linkBusy(linkBusy), .linkReadData(linkReadData),
      .linkReadValid(linkReadValid), .linkStart(linkStart), .linkPointerLoad(linkPointerLoad),
      .linkWriteByte(linkWriteByte), .linkReadByte(linkReadByte), .linkData(linkData));

   // Compare and count
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      checksDone++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("Error at %0t ns: seen %h, expected %h", $time, seen, exp);
      end
   endtask

   // Short host operations
   task automatic sta();
      u_rtcar_host_model.send(RTCAR_REQ_START, 8'h00, junk);
   endtask
   task automatic ptr(input logic [7:0] a);
      u_rtcar_host_model.send(RTCAR_REQ_POINTER, a, junk);
   endtask
   task automatic wrb(input logic [7:0] d);
      u_rtcar_host_model.send(RTCAR_REQ_WRITE, d, junk);
   endtask
   task automatic rdc(input logic [7:0] e);
      logic [7:0] v;
      u_rtcar_host_model.send(RTCAR_REQ_READ, 8'h00, v);
      check({8'h00, v}, {8'h00, e});
   endtask

   // Counts and verdict, the single end of the run
   task automatic give_verdict();
      $display("Checks %0d, miscompares %0d", checksDone, miscompares);
      if (miscompares == 0 && checksDone > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   // Main sequence
   initial
   begin
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      @(posedge linkClk);
      linkRst <= 1'b0;
      repeat (10) @(posedge clk);
      // Control and status after reset, stepping pointer
      ptr(8'h0E);
      rdc(8'h1C);
      rdc(8'h88);
      ptr(8'h0E);
      wrb(8'hE5);
      check({13'h0000, stopOsc, batSqw, convert}, 16'h0007);
      ptr(8'h07);
      for (int b = 0; b < 7; b++) wrb(ALARMS[b]);
      $display("Test setup done");
      // Rollovers: century, midnight, meridiem, BCD carry
      for (int i = 0; i < 4; i++)
      begin
         ptr(8'h00);
         for (int b = 0; b < 7; b++) wrb(setT[i][b]);
         sta();
         ptr(8'h00);
         rdc(8'h59);
         repeat (SEC) @(posedge clk);
         sta();
         ptr(8'h00);
         for (int b = 0; b < 7; b++) rdc(expT[i][b]);
         $display("Test rollover %0d done", i);
      end
      // Top of map, then wrap to seconds
      ptr(8'h11);
      rdc(8'hA5);
      rdc(8'h40);
      rdc(8'h00);
      // Second alarm flagged at zero seconds, not enabled on pin
      ptr(8'h0F);
      rdc(8'h8A);
      check({15'h0000, pinOeN}, 16'h0001);
      // First alarm matches weekday and time two ticks later
      repeat (2 * SEC) @(posedge clk);
      check({15'h0000, pinOeN}, 16'h0000);
      ptr(8'h0F);
      rdc(8'h8B);
      ptr(8'h0F);
      wrb(8'h08);
      repeat (2) @(posedge clk);
      check({14'h0000, pinOeN, khzOn}, 16'h0003);
      $display("Test alarms done");
      // Square wave: half of each second low
      ptr(8'h0E);
      wrb(8'h00);
      lows = 0;
      repeat (SEC)
      begin
         @(posedge clk);
         #1;
         lows += (pinOeN === 1'b0);
      end
      check(lows[15:0], 16'(SEC / 2));
      $display("Test square wave done");
      give_verdict();
   end

   // Watchdog well beyond the expected run
   initial
   begin
      #500000;
      miscompares++;
      give_verdict();
   end
endmodule // rtcar_calendar_alarm_regs_tb_top
